// ==== src/i2cm_core.sv ====
// two-wire master sequencer: start, byte transmit, acknowledge, stop, arbitration
// assumes open-drain pads outside; lines arrive asynchronous, software on AXI4-Lite
//
// Operation
// - ack enable pulls SCL low, drives ack bit
// - ack releases SCL, counts high, finishes idle
// - buffer write during sequence sets write clash
// - stop drives SDA low then counts
// - count end releases SCL, SDA later
// - stop seen flagged, interrupt one period later
// - rate generator waits for SCL high
// - sleep wake on completed byte if enabled
// - reset disables port, aborts transfer
// - start and stop flags cleared when disabled
// - bus stop raises interrupt when enabled
// - expected one sampled zero is collision
// - transmit collision clears full, releases lines
// - sequence collision aborts, clears enables
// - after collision, stop sets port flag
// - new buffer write starts at first bit
// - low line at start is collision
// - start counts with SDA high, SCL low collides
// - early SDA low asserts SDA early
// - start hold count, then SCL low
// - enables ignored while sequence runs
`timescale 1ns/10ps
`include "i2cm_regs.svh"

module i2cm_core
    import i2cm_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        sleep_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    output logic             port_irq_o,
    output logic             wake_o
);
    // address decode shared by reads and writes
    function automatic i2cm_sel_type reg_sel(input logic [7:0] a);
        if (a == `I2CM_OFF_CTRL) begin
            return SEL_CTRL;
        end else if (a == `I2CM_OFF_STAT) begin
            return SEL_STAT;
        end else if (a == `I2CM_OFF_RATE) begin
            return SEL_RATE;
        end else if (a == `I2CM_OFF_BUF) begin
            return SEL_BUF;
        end else begin
            return SEL_NONE;
        end
    endfunction : reg_sel

    // sda enable for bit slot k, msb first; slot eight released for the slave
    function automatic logic tx_oe(input logic [7:0] sh, input logic [3:0] k);
        if (k >= `I2CM_BITS_BYTE) begin
            return 1'b0;
        end else begin
            return ~sh[3'h7 - k[2:0]];
        end
    endfunction : tx_oe

    i2cm_state_type             st_q;
    i2cm_ctrl_type              ctrl_q;
    i2cm_stat_type              stat_q;
    logic [`I2CM_RATE_W-1:0]    rate_q;
    logic [`I2CM_RATE_W-1:0]    brg_q;
    logic [7:0]                 buf_q;
    logic [3:0]                 cnt_q;
    logic                       scl_oe_q;
    logic                       sda_oe_q;
    logic [1:0]                 scl_sync_q;
    logic [1:0]                 sda_sync_q;
    logic                       scl_prev_q;
    logic                       sda_prev_q;
    logic                       aw_hold_q;
    logic                       w_hold_q;
    logic [7:0]                 awaddr_q;
    logic [31:0]                wdata_q;
    logic                       wlane_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 rresp_q;
    logic                       scl_s;
    logic                       sda_s;
    logic                       tick;
    logic                       clash;
    logic                       stop_evt;
    logic                       start_evt;
    logic                       wr_fire;
    i2cm_sel_type               wsel;
    logic                       wr_ctrl;
    logic                       wr_stat;
    logic                       wr_rate;
    logic                       wr_buf;
    logic                       seq_busy;

    assign scl_s    = scl_sync_q[1];
    assign sda_s    = sda_sync_q[1];
    assign tick     = (brg_q == '0);
    assign seq_busy = ctrl_q.start_sequence_enable | ctrl_q.stop_sequence_enable | ctrl_q.ack_sequence_enable;

    // two flops per pad line, then a copy of the clean level for edges
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce_i) begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // start and stop conditions on the bus, whoever makes them
    assign start_evt = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_evt  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // write channel: address and data taken in either order
    assign s_axi_awready_o = ~aw_hold_q & ~bvalid_q;
    assign s_axi_wready_o  = ~w_hold_q & ~bvalid_q;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = bresp_q;
    assign wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
    assign wsel    = reg_sel(awaddr_q);
    assign wr_ctrl = wr_fire & wlane_q & (wsel == SEL_CTRL);
    assign wr_stat = wr_fire & wlane_q & (wsel == SEL_STAT);
    assign wr_rate = wr_fire & wlane_q & (wsel == SEL_RATE);
    assign wr_buf  = wr_fire & wlane_q & (wsel == SEL_BUF);

    // write address, data and response handshake
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wlane_q   <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `I2CM_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid_i & s_axi_awready_o) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i & s_axi_wready_o) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata_i;
                wlane_q  <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wsel == SEL_NONE) ? `I2CM_RESP_SLVERR : `I2CM_RESP_OKAY;
            end else if (bvalid_q & s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel: one outstanding read, data from flops
    assign s_axi_arready_o = ~rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = rresp_q;
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `I2CM_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i & ~rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q  <= `I2CM_RESP_OKAY;
                case (reg_sel(s_axi_araddr_i))
                    SEL_CTRL: rdata_q <= {26'h0, ctrl_q};
                    SEL_STAT: rdata_q <= {25'h0, stat_q};
                    SEL_RATE: rdata_q <= {25'h0, rate_q};
                    SEL_BUF:  rdata_q <= {24'h0, buf_q};
                    default: begin
                        rdata_q <= 32'h0000_0000;
                        rresp_q <= `I2CM_RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_q & s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // rate reload value
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rate_q <= `I2CM_RATE_RST;
        end else if (ce_i & wr_rate) begin
            rate_q <= wdata_q[`I2CM_RATE_W-1:0];
        end
    end

    // arbitration loss per state
    always_comb begin
        clash = 1'b0;
        case (st_q)
            ST_START_CHK: clash = ~sda_s | ~scl_s;
            ST_START_A:   clash = ~scl_s & sda_s;
            ST_TX_HIGH:   clash = ~sda_oe_q & (cnt_q < `I2CM_BITS_BYTE) & ~sda_s;
            ST_ACK_HIGH:  clash = ~sda_oe_q & ~sda_s;
            ST_STOP_HIGH: clash = ~scl_s;
            ST_STOP_DET:  clash = tick & ~sda_s;
            default:      clash = 1'b0;
        endcase
    end

    // sequencer, rate generator, control and sticky status
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_q     <= ST_IDLE;
            ctrl_q   <= '0;
            stat_q   <= '0;
            brg_q    <= `I2CM_RATE_RST;
            buf_q    <= 8'h00;
            cnt_q    <= 4'h0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (ce_i) begin
            if (brg_q != '0) begin
                brg_q <= brg_q - 1'b1;
            end
            if (wr_ctrl) begin
                ctrl_q.enable        <= wdata_q[`I2CM_CTRL_EN];
                ctrl_q.irq_en        <= wdata_q[`I2CM_CTRL_IRQEN];
                ctrl_q.ack_value_bit <= wdata_q[`I2CM_CTRL_ACKVAL];
                if (st_q == ST_IDLE && !seq_busy) begin
                    ctrl_q.start_sequence_enable <= wdata_q[`I2CM_CTRL_START];
                    ctrl_q.stop_sequence_enable  <= wdata_q[`I2CM_CTRL_STOP];
                    ctrl_q.ack_sequence_enable   <= wdata_q[`I2CM_CTRL_ACK];
                end
            end
            // software clears flags; hardware sets below win
            if (wr_stat) begin
                if (wdata_q[`I2CM_STAT_PIF]) stat_q.port_interrupt_flag <= 1'b0;
                if (wdata_q[`I2CM_STAT_BCL]) stat_q.collision_interrupt_flag <= 1'b0;
                if (wdata_q[`I2CM_STAT_WRITE_CLASH_FLAG]) stat_q.write_clash_flag <= 1'b0;
            end
            if (wr_buf && (st_q != ST_IDLE || seq_busy || stat_q.buffer_full_flag)) begin
                stat_q.write_clash_flag <= 1'b1;
            end
            if (start_evt) begin
                stat_q.start_seen <= 1'b1;
                stat_q.stop_seen  <= 1'b0;
            end else if (stop_evt) begin
                stat_q.stop_seen  <= 1'b1;
                stat_q.start_seen <= 1'b0;
            end
            if (stop_evt && st_q == ST_IDLE) begin
                stat_q.port_interrupt_flag <= 1'b1;
            end
            if (!ctrl_q.enable) begin
                st_q              <= ST_IDLE;
                scl_oe_q          <= 1'b0;
                sda_oe_q          <= 1'b0;
                stat_q.start_seen <= 1'b0;
                stat_q.stop_seen  <= 1'b0;
                stat_q.buffer_full_flag <= 1'b0;
                ctrl_q.start_sequence_enable <= 1'b0;
                ctrl_q.stop_sequence_enable  <= 1'b0;
                ctrl_q.ack_sequence_enable   <= 1'b0;
            end else if (clash) begin
                stat_q.collision_interrupt_flag <= 1'b1;
                stat_q.buffer_full_flag <= 1'b0;
                ctrl_q.start_sequence_enable <= 1'b0;
                ctrl_q.stop_sequence_enable  <= 1'b0;
                ctrl_q.ack_sequence_enable   <= 1'b0;
                st_q     <= ST_IDLE;
                scl_oe_q <= 1'b0;
                sda_oe_q <= 1'b0;
                cnt_q    <= 4'h0;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        if (wr_buf && !seq_busy && !stat_q.buffer_full_flag) begin
                            buf_q    <= wdata_q[7:0];
                            cnt_q    <= 4'h0;
                            stat_q.buffer_full_flag <= 1'b1;
                            scl_oe_q <= 1'b1;
                            sda_oe_q <= tx_oe(wdata_q[7:0], 4'h0);
                            brg_q    <= rate_q;
                            st_q     <= ST_TX_LOW;
                        end else if (ctrl_q.start_sequence_enable) begin
                            scl_oe_q <= 1'b0;
                            sda_oe_q <= 1'b0;
                            st_q     <= ST_START_CHK;
                        end else if (ctrl_q.stop_sequence_enable) begin
                            scl_oe_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                            st_q     <= ST_STOP_SDA;
                        end else if (ctrl_q.ack_sequence_enable) begin
                            scl_oe_q <= 1'b1;
                            sda_oe_q <= ~ctrl_q.ack_value_bit;
                            brg_q    <= rate_q;
                            st_q     <= ST_ACK_LOW;
                        end
                    end
                    ST_START_CHK: begin
                        brg_q <= rate_q;
                        st_q  <= ST_START_A;
                    end
                    ST_START_A: begin
                        if (!sda_s || tick) begin
                            sda_oe_q <= 1'b1;
                            brg_q    <= rate_q;
                            st_q     <= ST_START_B;
                        end
                    end
                    ST_START_B: begin
                        if (tick) begin
                            scl_oe_q <= 1'b1;
                            ctrl_q.start_sequence_enable <= 1'b0;
                            stat_q.port_interrupt_flag <= 1'b1;
                            st_q     <= ST_IDLE;
                        end
                    end
                    ST_TX_LOW: begin
                        if (tick) begin
                            scl_oe_q <= 1'b0;
                            st_q     <= ST_TX_WAIT;
                        end
                    end
                    ST_TX_HIGH: begin
                        if (tick) begin
                            scl_oe_q <= 1'b1;
                            brg_q    <= rate_q;
                            if (cnt_q == `I2CM_BITS_BYTE) begin
                                stat_q.ack_status <= sda_s;
                                stat_q.port_interrupt_flag <= 1'b1;
                                cnt_q    <= 4'h0;
                                st_q     <= ST_IDLE;
                            end else begin
                                if (cnt_q == `I2CM_BITS_BYTE - 4'h1) begin
                                    stat_q.buffer_full_flag <= 1'b0;
                                end
                                sda_oe_q <= tx_oe(buf_q, cnt_q + 4'h1);
                                cnt_q    <= cnt_q + 4'h1;
                                st_q     <= ST_TX_LOW;
                            end
                        end
                    end
                    ST_ACK_LOW: begin
                        if (tick) begin
                            scl_oe_q <= 1'b0;
                            st_q     <= ST_ACK_WAIT;
                        end
                    end
                    ST_ACK_HIGH: begin
                        if (tick) begin
                            scl_oe_q <= 1'b1;
                            ctrl_q.ack_sequence_enable <= 1'b0;
                            st_q     <= ST_IDLE;
                        end
                    end
                    ST_STOP_SDA: begin
                        if (!sda_s) begin
                            brg_q <= rate_q;
                            st_q  <= ST_STOP_LOW;
                        end
                    end
                    ST_STOP_LOW: begin
                        if (tick) begin
                            scl_oe_q <= 1'b0;
                            st_q     <= ST_STOP_WAIT;
                        end
                    end
                    ST_STOP_HIGH: begin
                        if (tick) begin
                            sda_oe_q <= 1'b0;
                            brg_q    <= rate_q;
                            st_q     <= ST_STOP_DET;
                        end
                    end
                    ST_STOP_DET: begin
                        if (sda_s && scl_s) begin
                            stat_q.stop_seen <= 1'b1;
                            brg_q <= rate_q;
                            st_q  <= ST_STOP_FIN;
                        end
                    end
                    ST_STOP_FIN: begin
                        if (tick) begin
                            ctrl_q.stop_sequence_enable <= 1'b0;
                            stat_q.port_interrupt_flag <= 1'b1;
                            st_q <= ST_IDLE;
                        end
                    end
                    default: begin
                        if (scl_s) begin
                            brg_q <= rate_q;
                            st_q  <= (st_q == ST_TX_WAIT) ? ST_TX_HIGH :
                                     (st_q == ST_ACK_WAIT) ? ST_ACK_HIGH : ST_STOP_HIGH;
                        end
                    end
                endcase
            end
        end
    end

    // pads only pulled low or released
    assign scl_o    = 1'b0;
    assign sda_o    = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;

    assign port_irq_o = stat_q.port_interrupt_flag & ctrl_q.irq_en;
    assign wake_o     = sleep_i & port_irq_o;
endmodule : i2cm_core

// ==== common/i2cm_regs.svh ====
// register map, field positions, reset values and bus answers of the two-wire sequencer
// assumes inclusion by name from the core only
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
// byte offsets on the register bus
`define I2CM_OFF_CTRL     8'h00
`define I2CM_OFF_STAT     8'h04
`define I2CM_OFF_RATE     8'h08
`define I2CM_OFF_BUF      8'h0C
// sequence_control_reg field positions
`define I2CM_CTRL_EN      0
`define I2CM_CTRL_START   1
`define I2CM_CTRL_STOP    2
`define I2CM_CTRL_ACK     3
`define I2CM_CTRL_ACKVAL  4
`define I2CM_CTRL_IRQEN   5
// port_state_reg field positions
`define I2CM_STAT_PIF     0
`define I2CM_STAT_BCL     1
`define I2CM_STAT_WRITE_CLASH_FLAG    2
`define I2CM_STAT_BF      3
`define I2CM_STAT_START   4
`define I2CM_STAT_STOP    5
`define I2CM_STAT_ACKST   6
// reset values and widths
`define I2CM_RATE_RST     7'h00
`define I2CM_RATE_W       7
`define I2CM_BITS_BYTE    4'h8
// bus answers
`define I2CM_RESP_OKAY    2'h0
`define I2CM_RESP_SLVERR  2'h2
`endif

// ==== common/i2cm_pkg.sv ====
// types shared by the two-wire sequencer
// assumes the register header sits beside it on the include path
package i2cm_pkg;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_START_CHK, ST_START_A, ST_START_B,
        ST_TX_LOW, ST_TX_WAIT, ST_TX_HIGH,
        ST_ACK_LOW, ST_ACK_WAIT, ST_ACK_HIGH,
        ST_STOP_SDA, ST_STOP_LOW, ST_STOP_WAIT, ST_STOP_HIGH, ST_STOP_DET, ST_STOP_FIN
    } i2cm_state_type;
    // register selector
    typedef enum logic [2:0] {SEL_CTRL, SEL_STAT, SEL_RATE, SEL_BUF, SEL_NONE} i2cm_sel_type;
    // software control bits
    typedef struct packed {
        logic irq_en;
        logic ack_value_bit;
        logic ack_sequence_enable;
        logic stop_sequence_enable;
        logic start_sequence_enable;
        logic enable;
    } i2cm_ctrl_type;
    // sticky and live status bits
    typedef struct packed {
        logic ack_status;
        logic stop_seen;
        logic start_seen;
        logic buffer_full_flag;
        logic write_clash_flag;
        logic collision_interrupt_flag;
        logic port_interrupt_flag;
    } i2cm_stat_type;
endpackage : i2cm_pkg

// ==== verification/i2cm_core_asserts.sv ====
// port checker for the two-wire sequencer, bound onto its core
// assumes clock enable held high and pull-ups on both lines
`timescale 1ns/10ps
module i2cm_core_asserts (
    input wire logic ref_clk_i, sys_rst_i, sleep_i, s_axi_awvalid_i, s_axi_awready_o,
    input wire logic s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
    input wire logic scl_o, scl_oe_o, sda_o, sda_oe_o, port_irq_o, wake_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // line, wake and bus-answer relations
    a_reset_idle: assert property (disable iff (1'b0) sys_rst_i |=> !scl_oe_o && !sda_oe_o)
        else $error("line pulled after reset");
    a_lines_low_only: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    a_wake_gate: assert property (wake_o == (sleep_i && port_irq_o))
        else $error("wake mismatch");
    a_scl_high_min: assert property ($fell(scl_oe_o) |-> !scl_oe_o[*3])
        else $error("high time short");
    a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##2 s_axi_bvalid_o) else $error("bvalid late");
    a_write_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid held");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data late");
    a_read_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read data repeated");
endmodule : i2cm_core_asserts
bind i2cm_core i2cm_core_asserts u_i2cm_core_asserts (.*);

// ==== verification/i2cm_bus_model.sv ====
// open-drain bus with pull-ups and one acknowledging, stretching slave
// assumes enables high while the design pulls a line low
`timescale 1ns/10ps
module i2cm_bus_model (
    input  wire logic       clk_i, scl_oe_i, sda_oe_i, grab_i,
    input  wire logic [3:0] stretch_i,
    output logic            scl_o, sda_o,
    output logic [8:0]      rx_o = '0
);
    logic [3:0] hold_q = '0, cnt_q = '0;
    logic       ack_q = 1'b0, scl_q = 1'b1, sda_q = 1'b1;
    assign scl_o = !(scl_oe_i || hold_q != 4'h0);
    assign sda_o = !(sda_oe_i || grab_i || ack_q);
    // stretch low phase; slave acks ninth slot
    always @(posedge clk_i) begin
        scl_q <= scl_o;
        sda_q <= sda_o;
        hold_q <= (scl_q && !scl_o) ? stretch_i : (hold_q != 4'h0 ? hold_q - 4'h1 : 4'h0);
        if (scl_o && scl_q && sda_q && !sda_o) cnt_q <= 4'h0;
        else if (scl_q && !scl_o) cnt_q <= cnt_q + 4'h1;
        ack_q <= (cnt_q == 4'h9);
        if (!scl_q && scl_o) rx_o <= {rx_o[7:0], sda_o};
    end
endmodule : i2cm_bus_model

// ==== verification/i2cm_core_tb.sv ====
// self-checking bench for the two-wire sequencer over AXI4-Lite
// assumes bus model and checker compiled before it
`timescale 1ns/10ps
module i2cm_core_tb;
    logic clk = 0, rst = 1, slp = 0, awv = 0, wv = 0, arv = 0, grab = 0, seen = 0;
    logic [7:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rd;
    logic [3:0] st = 0;
    logic [1:0] br, rr;
    logic [8:0] rx;
    logic awrdy, wrdy, bv, arr, rv, soe, doe, irq, wake, scl, sda;
    int err_total = 0, checks_done = 0;
    initial forever #12.5 clk = ~clk;
    // notes any data-line pull by the design
    always @(posedge clk) if (doe) seen <= 1'b1;
    i2cm_core u_i2cm_core (.ref_clk_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .sleep_i(slp), .s_axi_awaddr_i(aa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(1'b1), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(1'b1), .scl_i(scl), .scl_o(), .scl_oe_o(soe), .sda_i(sda), .sda_o(),
        .sda_oe_o(doe), .port_irq_o(irq), .wake_o(wake));
    i2cm_bus_model u_i2cm_bus_model (.clk_i(clk), .scl_oe_i(soe), .sda_oe_i(doe), .grab_i(grab),
        .stretch_i(st), .scl_o(scl), .sda_o(sda), .rx_o(rx));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic tmo;
        err_total++;
        $display("Error %0t: wait ran out", $time);
        tally_and_finish;
    endtask : tmo
    // write: address and data offered together, released as taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        aa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            ta = awv && awrdy; tw = wv && wrdy;
            if (bv && !awv && !wv) begin chk(br, {a > 8'h0C, 1'b0}); @(posedge clk); return; end
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        tmo;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tv;
        ra <= a; arv <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            d = rd; r = rr; ta = arv && arr; tv = rv;
            @(posedge clk);
            if (ta) arv <= 1'b0;
            if (tv) return;
        end
        tmo;
    endtask : axr
    task automatic ck(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        logic [31:0] d; logic [1:0] r;
        axr(a, d, r);
        chk(d & m, e);
        chk(r, er);
    endtask : ck
    task automatic waitb(input logic [7:0] a, input int b, input logic v);
        logic [31:0] d; logic [1:0] r;
        for (int n = 0; n < 400; n++) begin axr(a, d, r); if (d[b] === v) return; end
        tmo;
    endtask : waitb
    // start on free bus, byte from first bit
    task automatic start_send(input logic [7:0] b);
        axw(8'h00, 32'h23); waitb(8'h04, 0, 1'b1); axw(8'h04, 32'h1);
        if (b != 8'h00) begin axw(8'h0C, {24'h0, b}); waitb(8'h04, 0, 1'b1); chk(rx[8:1], b); end
    endtask : start_send
    task automatic t_reset;
        ck(8'h00, 32'hFF, 32'h0, 2'h0);
        ck(8'h04, 32'h3F, 32'h0, 2'h0);
        axw(8'h10, 32'h1); ck(8'h10, 32'hFFFF_FFFF, 32'h0, 2'h2);
        axw(8'h08, 32'hFF); ck(8'h08, 32'hFFFF_FFFF, 32'h7F, 2'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_xfer;
        axw(8'h08, 32'h3); st <= 4'h6; axw(8'h00, 32'h21);
        start_send(8'hA5);
        ck(8'h04, 32'h48, 32'h0, 2'h0);
        axw(8'h04, 32'h1);
        for (int v = 1; v >= 0; v--) begin
            seen = 1'b0;
            axw(8'h00, 32'h29 | (v << 4)); axw(8'h0C, 32'h11);
            ck(8'h04, 32'h04, 32'h04, 2'h0);
            axw(8'h04, 32'h04); waitb(8'h00, 3, 1'b0);
            chk(soe, 1'b1);
            chk(seen, !v);
        end
        axw(8'h00, 32'h25); axw(8'h0C, 32'h11);
        ck(8'h04, 32'h04, 32'h04, 2'h0);
        waitb(8'h04, 0, 1'b1); ck(8'h04, 32'h20, 32'h20, 2'h0);
        ck(8'h00, 32'h04, 32'h0, 2'h0);
        chk({soe, doe, irq}, 3'b001);
        slp <= 1'b1; @(posedge clk);
        chk(wake, 1'b1);
        slp <= 1'b0; axw(8'h04, 32'h5);
        $display("transfer test done");
    endtask : t_xfer
    task automatic t_coll;
        grab <= 1'b1; axw(8'h00, 32'h23); waitb(8'h04, 1, 1'b1);
        ck(8'h00, 32'h02, 32'h0, 2'h0);
        grab <= 1'b0; waitb(8'h04, 0, 1'b1); axw(8'h04, 32'h3);
        start_send(8'h00); axw(8'h0C, 32'h80); grab <= 1'b1;
        waitb(8'h04, 1, 1'b1); ck(8'h04, 32'h08, 32'h0, 2'h0);
        chk({soe, doe}, 2'b00);
        grab <= 1'b0; waitb(8'h04, 0, 1'b1); axw(8'h04, 32'h3);
        start_send(8'hC3);
        rst <= 1'b1; @(posedge clk); rst <= 1'b0; @(negedge clk); chk({soe, doe}, 2'b00);
        $display("collision test done");
    endtask : t_coll
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset; t_xfer; t_coll;
        tally_and_finish;
    end
endmodule : i2cm_core_tb
